// >>> core/sld_pkg.sv
// Constants and types for the synthesizer loop divider configuration bank.
// Function
// - Bypass bit skips loop filter, resets clear.
// - Reference divider ratio six bits, resets one.
// - Feedback integer eight bits, resets 100.
// - Fraction word 24 bits, three bytes, low first.
// - Modulus word 24 bits, three bytes, low first.
// - Cascade ratio twelve bits, values 4-4095 valid.
// - Fixed-delay divider divides by field plus one.
// - Fixed-delay phase offset in half input periods.
// - Loop mode 10 selects fixed-delay feedback path.
// - Modulator power-down bit resets to one.
`default_nettype none
package sld_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [8:0] OFF_LOOP_CTRL = 9'h101;
  localparam logic [8:0] OFF_FILT_BYP = 9'h104;
  localparam logic [8:0] OFF_REF_DIV = 9'h105;
  localparam logic [8:0] OFF_FB_INT = 9'h107;
  localparam logic [8:0] OFF_FRAC0 = 9'h108;
  localparam logic [8:0] OFF_FRAC1 = 9'h109;
  localparam logic [8:0] OFF_FRAC2 = 9'h10A;
  localparam logic [8:0] OFF_MOD0 = 9'h10B;
  localparam logic [8:0] OFF_MOD1 = 9'h10C;
  localparam logic [8:0] OFF_MOD2 = 9'h10D;
  localparam logic [8:0] OFF_CASC_LO = 9'h10E;
  localparam logic [8:0] OFF_CASC_HI = 9'h10F;
  localparam logic [8:0] OFF_FD_RATIO = 9'h110;
  localparam logic [8:0] OFF_FD_PHASE = 9'h111;
  localparam logic [8:0] OFF_STATUS = 9'h112;
  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic RST_FILT_BYP = 1'b0;
  localparam logic RST_SDM_PD = 1'b1;
  localparam logic [5:0] RST_REF_DIV = 6'h01;
  localparam logic [7:0] RST_FB_INT = 8'h64;
  localparam logic [23:0] RST_WORD = 24'h000000;
  localparam logic [11:0] RST_CASC = 12'h000;
  localparam logic [5:0] RST_FD = 6'h00;
  localparam logic [7:0] INT_MIN_VALID = 8'h0C;
  localparam logic [7:0] INT_FULL_LO = 8'h0F;
  localparam logic [7:0] INT_FULL_HI = 8'hFC;
  localparam logic [11:0] CASC_MIN = 12'h004;
  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int ST_INT_BAD = 0;
  localparam int ST_INT_SDM = 1;
  localparam int ST_CASC_BAD = 2;
  localparam int ST_MOD_BAD = 3;
  localparam int ST_MODE_BAD = 4;
  localparam int ST_REF_BAD = 5;
  localparam int ST_W = 6;
  typedef enum logic [1:0] {
    LM_SINGLE = 2'h0,
    LM_CASCADE = 2'h1,
    LM_FIXED = 2'h2,
    LM_RSVD = 2'h3
  } sld_loop_mode_type;
endpackage : sld_pkg
`default_nettype wire

// >>> core/sld_cfg_if.sv
// Configuration fields passed from the register bank to its consumers.
`timescale 1ns/1ps
`default_nettype none
interface sld_cfg_if;
  logic [5:0] ref_ratio;
  logic [7:0] int_ratio;
  logic [23:0] frac;
  logic [23:0] modulus;
  logic [11:0] casc;
  logic [5:0] fd_ratio;
  logic [5:0] fd_phase;
  logic [1:0] loop_mode;
  logic sdm_pd;
  modport src (output ref_ratio, int_ratio, frac, modulus, casc, fd_ratio, fd_phase, loop_mode, sdm_pd);
  modport snk (input ref_ratio, int_ratio, frac, modulus, casc, fd_ratio, fd_phase, loop_mode, sdm_pd);
endinterface : sld_cfg_if
`default_nettype wire

// >>> core/sld_fb_check.sv
// Feedback path selection and configuration consistency checks.
`timescale 1ns/1ps
`default_nettype none
module sld_fb_check (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  sld_cfg_if.snk cfg,
  output logic [2:0] path_o,
  output logic sdm_en_o,
  output logic [sld_pkg::ST_W-1:0] err_o
);
  logic [2:0] path_reg;
  logic sdm_en_reg;
  logic [sld_pkg::ST_W-1:0] err_reg;
  wire [2:0] path_next;
  wire [sld_pkg::ST_W-1:0] err_next;
  wire int_low;
  wire int_edge;
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign int_low = cfg.int_ratio < sld_pkg::INT_MIN_VALID;
  assign int_edge = ~int_low & ((cfg.int_ratio < sld_pkg::INT_FULL_LO) |
                                (cfg.int_ratio > sld_pkg::INT_FULL_HI));
  // The reserved mode selects no path so the loop is never fed a bogus divider.
  assign path_next = (cfg.loop_mode == sld_pkg::LM_SINGLE) ? 3'h1 :
                     (cfg.loop_mode == sld_pkg::LM_CASCADE) ? 3'h2 :
                     (cfg.loop_mode == sld_pkg::LM_FIXED) ? 3'h4 : 3'h0;
  assign err_next[sld_pkg::ST_INT_BAD] = int_low;
  assign err_next[sld_pkg::ST_INT_SDM] = int_edge & ~cfg.sdm_pd;
  assign err_next[sld_pkg::ST_CASC_BAD] = cfg.casc < sld_pkg::CASC_MIN;
  assign err_next[sld_pkg::ST_MOD_BAD] = cfg.modulus <= cfg.frac;
  assign err_next[sld_pkg::ST_MODE_BAD] = cfg.loop_mode == sld_pkg::LM_RSVD;
  assign err_next[sld_pkg::ST_REF_BAD] = cfg.ref_ratio == 6'h00;

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      path_reg <= 3'h0;
      sdm_en_reg <= 1'b0;
      err_reg <= '0;
    end
    else
    begin
      path_reg <= path_next;
      sdm_en_reg <= ~cfg.sdm_pd;
      err_reg <= err_next;
    end
  end
  assign path_o = path_reg;
  assign sdm_en_o = sdm_en_reg;
  assign err_o = err_reg;

  a_int_invalid_flag: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (cfg.int_ratio < 8'h0C) |=> err_o[0])
    else $error("Low feedback integer not flagged.");
  a_fixed_path_sel: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (cfg.loop_mode == 2'h2) |=> (path_o == 3'h4))
    else $error("Fixed-delay path not selected in mode 10.");
  a_sdm_edge_flag: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!cfg.sdm_pd && cfg.int_ratio == 8'hFD) |=> err_o[1])
    else $error("Edge integer with modulator on not flagged.");
endmodule : sld_fb_check
`default_nettype wire

// >>> core/sld_fixed_div.sv
// Fixed-delay feedback divider counting half periods of its input clock.
`timescale 1ns/1ps
`default_nettype none
module sld_fixed_div (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic enable_i,
  input wire logic restart_i,
  input wire logic half_tick_i,
  input wire logic [5:0] ratio_i,
  input wire logic [5:0] phase_i,
  output logic div_o
);
  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;
  logic out_reg;
  wire [6:0] last_half;
  wire [6:0] high_len;
  wire load;
  // Ratio field plus one input periods make one output period of twice as many halves.
  assign last_half = {ratio_i, 1'b1};
  assign high_len = {1'b0, ratio_i} + 7'h01;
  assign load = restart_i | ~enable_i;
  // A phase above the period wraps at the next tick rather than stalling.
  always_comb
  begin
    cnt_next = cnt_reg;
    if (load)
      cnt_next = {1'b0, phase_i};
    else if (half_tick_i)
      cnt_next = (cnt_reg >= last_half) ? 7'h00 : cnt_reg + 7'h01;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      cnt_reg <= 7'h00;
      out_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      out_reg <= enable_i & (cnt_next < high_len);
    end
  end
  assign div_o = out_reg;

  a_fd_wrap_at: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!load && half_tick_i && cnt_reg == {ratio_i, 1'b1}) |=> (cnt_reg == 7'h00))
    else $error("Fixed-delay counter did not wrap at ratio plus one periods.");
  a_fd_phase_load: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (restart_i && enable_i) |=> (cnt_reg == {1'b0, $past(phase_i)}))
    else $error("Fixed-delay phase not loaded on restart.");
endmodule : sld_fixed_div
`default_nettype wire

// >>> core/sld_regbank.sv
// Register bank for the synthesizer loop divider configuration.
`timescale 1ns/1ps
`default_nettype none
module sld_regbank (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [sld_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [sld_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [sld_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic fd_half_tick_i,
  input wire logic fd_restart_i,
  output logic loop_filter_bypass_o,
  output logic [5:0] ref_div_ratio_o,
  output logic [7:0] fb_int_ratio_o,
  output logic [23:0] sdm_frac_o,
  output logic [23:0] sdm_mod_o,
  output logic sdm_enable_o,
  output logic [11:0] cascade_ratio_o,
  output logic [2:0] fb_path_o,
  output logic fd_div_o,
  output logic config_error_o
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic filt_byp_reg;
  logic sdm_pd_reg;
  logic [1:0] loop_mode_reg;
  logic [5:0] ref_div_reg;
  logic [7:0] fb_int_reg;
  logic [7:0] frac_reg [3];
  logic [7:0] mod_reg [3];
  logic [7:0] casc_lo_reg;
  logic [3:0] casc_hi_reg;
  logic [5:0] fd_ratio_reg;
  logic [5:0] fd_phase_reg;
  logic [7:0] rdata_reg;
  logic [sld_pkg::DATA_W-1:0] rdata_next;

  sld_cfg_if cfg ();
  wire [2:0] path;
  wire sdm_en;
  wire [sld_pkg::ST_W-1:0] err;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire hit_ctrl = reg_addr_i == sld_pkg::OFF_LOOP_CTRL;
  wire hit_filt = reg_addr_i == sld_pkg::OFF_FILT_BYP;
  wire hit_ref = reg_addr_i == sld_pkg::OFF_REF_DIV;
  wire hit_int = reg_addr_i == sld_pkg::OFF_FB_INT;
  wire hit_clo = reg_addr_i == sld_pkg::OFF_CASC_LO;
  wire hit_chi = reg_addr_i == sld_pkg::OFF_CASC_HI;
  wire hit_fdr = reg_addr_i == sld_pkg::OFF_FD_RATIO;
  wire hit_fdp = reg_addr_i == sld_pkg::OFF_FD_PHASE;
  wire hit_st = reg_addr_i == sld_pkg::OFF_STATUS;
  wire [2:0] hit_frac;
  wire [2:0] hit_mod;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_word
      assign hit_frac[gi] = reg_addr_i == sld_pkg::OFF_FRAC0 + 9'(gi);
      assign hit_mod[gi] = reg_addr_i == sld_pkg::OFF_MOD0 + 9'(gi);
      always_ff @(posedge core_clk_i)
      begin
        if (sys_rst_i)
        begin
          frac_reg[gi] <= sld_pkg::RST_WORD[gi*8 +: 8];
          mod_reg[gi] <= sld_pkg::RST_WORD[gi*8 +: 8];
        end
        else
        begin
          if (reg_wr_i && hit_frac[gi])
            frac_reg[gi] <= reg_wdata_i;
          if (reg_wr_i && hit_mod[gi])
            mod_reg[gi] <= reg_wdata_i;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Control and ratio registers
  // ----------------------------------------------------------------
  // Only the documented field bits are stored, so reserved bits cannot steer anything.
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      filt_byp_reg <= sld_pkg::RST_FILT_BYP;
      sdm_pd_reg <= sld_pkg::RST_SDM_PD;
      loop_mode_reg <= sld_pkg::LM_SINGLE;
      ref_div_reg <= sld_pkg::RST_REF_DIV;
      fb_int_reg <= sld_pkg::RST_FB_INT;
    end
    else
    begin
      if (reg_wr_i && hit_filt)
        filt_byp_reg <= reg_wdata_i[0];
      if (reg_wr_i && hit_ctrl)
      begin
        sdm_pd_reg <= reg_wdata_i[0];
        loop_mode_reg <= reg_wdata_i[2:1];
      end
      if (reg_wr_i && hit_ref)
        ref_div_reg <= reg_wdata_i[5:0];
      if (reg_wr_i && hit_int)
        fb_int_reg <= reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      casc_lo_reg <= sld_pkg::RST_CASC[7:0];
      casc_hi_reg <= sld_pkg::RST_CASC[11:8];
      fd_ratio_reg <= sld_pkg::RST_FD;
      fd_phase_reg <= sld_pkg::RST_FD;
    end
    else
    begin
      if (reg_wr_i && hit_clo)
        casc_lo_reg <= reg_wdata_i;
      if (reg_wr_i && hit_chi)
        casc_hi_reg <= reg_wdata_i[3:0];
      if (reg_wr_i && hit_fdr)
        fd_ratio_reg <= reg_wdata_i[5:0];
      if (reg_wr_i && hit_fdp)
        fd_phase_reg <= reg_wdata_i[5:0];
    end
  end

  // ----------------------------------------------------------------
  // Configuration fan-out
  // ----------------------------------------------------------------
  assign cfg.ref_ratio = ref_div_reg;
  assign cfg.int_ratio = fb_int_reg;
  assign cfg.frac = {frac_reg[2], frac_reg[1], frac_reg[0]};
  assign cfg.modulus = {mod_reg[2], mod_reg[1], mod_reg[0]};
  assign cfg.casc = {casc_hi_reg, casc_lo_reg};
  assign cfg.fd_ratio = fd_ratio_reg;
  assign cfg.fd_phase = fd_phase_reg;
  assign cfg.loop_mode = loop_mode_reg;
  assign cfg.sdm_pd = sdm_pd_reg;

  sld_fb_check u_check (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .cfg(cfg),
    .path_o(path),
    .sdm_en_o(sdm_en),
    .err_o(err)
  );

  // The divider only runs while it is the selected feedback path.
  sld_fixed_div u_fixed_div (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .enable_i(path[2]),
    .restart_i(fd_restart_i),
    .half_tick_i(fd_half_tick_i),
    .ratio_i(cfg.fd_ratio),
    .phase_i(cfg.fd_phase),
    .div_o(fd_div_o)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped addresses and reserved bits read as zero.
  assign rdata_next =
    hit_ctrl ? {5'h00, loop_mode_reg, sdm_pd_reg} :
    hit_filt ? {7'h00, filt_byp_reg} :
    hit_ref ? {2'h0, ref_div_reg} :
    hit_int ? fb_int_reg :
    hit_frac[0] ? frac_reg[0] :
    hit_frac[1] ? frac_reg[1] :
    hit_frac[2] ? frac_reg[2] :
    hit_mod[0] ? mod_reg[0] :
    hit_mod[1] ? mod_reg[1] :
    hit_mod[2] ? mod_reg[2] :
    hit_clo ? casc_lo_reg :
    hit_chi ? {4'h0, casc_hi_reg} :
    hit_fdr ? {2'h0, fd_ratio_reg} :
    hit_fdp ? {2'h0, fd_phase_reg} :
    hit_st ? {2'h0, err} : 8'h00;

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= reg_rd_i ? rdata_next : 8'h00;
  end

  assign reg_rdata_o = rdata_reg;
  assign loop_filter_bypass_o = filt_byp_reg;
  assign ref_div_ratio_o = ref_div_reg;
  assign fb_int_ratio_o = fb_int_reg;
  assign sdm_frac_o = cfg.frac;
  assign sdm_mod_o = cfg.modulus;
  assign sdm_enable_o = sdm_en;
  assign cascade_ratio_o = cfg.casc;
  assign fb_path_o = path;
  assign config_error_o = |err;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_int_write_read;
    (reg_wr_i && hit_int) ##1 (reg_rd_i && hit_int);
  endsequence

  sequence s_fd_write_read;
    (reg_wr_i && hit_fdr) ##1 (reg_rd_i && hit_fdr);
  endsequence

  a_filt_reset_clear: assert property ($fell(sys_rst_i) |-> !loop_filter_bypass_o)
    else $error("Filter bypass not clear after reset.");
  a_ref_reset_one: assert property ($fell(sys_rst_i) |-> ref_div_ratio_o == 6'h01)
    else $error("Reference ratio not one after reset.");
  a_int_reset_val: assert property ($fell(sys_rst_i) |-> fb_int_ratio_o == 8'h64)
    else $error("Feedback integer not 100 after reset.");
  a_sdm_pd_reset: assert property ($fell(sys_rst_i) |-> !sdm_enable_o ##1 !sdm_enable_o)
    else $error("Modulator not powered down after reset.");
  a_int_readback: assert property (s_int_write_read |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("Feedback integer readback mismatch.");
  a_fd_rsvd_zero: assert property (s_fd_write_read |=>
    reg_rdata_o == {2'h0, $past(reg_wdata_i[5:0], 2)})
    else $error("Fixed-delay ratio reserved bits not zero.");
  a_frac_byte_high: assert property ((reg_wr_i && reg_addr_i == 9'h10A) |=>
    sdm_frac_o[23:16] == $past(reg_wdata_i))
    else $error("Fraction high byte misplaced.");
  a_mod_byte_low: assert property ((reg_wr_i && reg_addr_i == 9'h10B) |=>
    sdm_mod_o[7:0] == $past(reg_wdata_i))
    else $error("Modulus low byte misplaced.");
  a_casc_high_nib: assert property ((reg_wr_i && reg_addr_i == 9'h10F) |=>
    cascade_ratio_o[11:8] == $past(reg_wdata_i[3:0]))
    else $error("Cascade ratio high bits misplaced.");
  a_read_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("Read data not zero outside read answer.");

  // ----------------------------------------------------------------
  // Byte lane, readback and reset checks
  // ----------------------------------------------------------------
  // Every lane is watched on its own, since a swapped pair of lanes passes any symmetric pattern.
  sequence s_ctrl_write_read;
    (reg_wr_i && hit_ctrl) ##1 (reg_rd_i && hit_ctrl);
  endsequence

  sequence s_casc_write_read;
    (reg_wr_i && hit_chi) ##1 (reg_rd_i && hit_chi);
  endsequence

  a_frac_byte_low: assert property ((reg_wr_i && reg_addr_i == 9'h108) |=>
    sdm_frac_o[7:0] == $past(reg_wdata_i))
    else $error("Fraction low byte misplaced.");
  a_frac_byte_mid: assert property ((reg_wr_i && reg_addr_i == 9'h109) |=>
    sdm_frac_o[15:8] == $past(reg_wdata_i))
    else $error("Fraction middle byte misplaced.");
  a_mod_byte_mid: assert property ((reg_wr_i && reg_addr_i == 9'h10C) |=>
    sdm_mod_o[15:8] == $past(reg_wdata_i))
    else $error("Modulus middle byte misplaced.");
  a_mod_byte_top: assert property ((reg_wr_i && reg_addr_i == 9'h10D) |=>
    sdm_mod_o[23:16] == $past(reg_wdata_i))
    else $error("Modulus high byte misplaced.");
  a_casc_low_byte: assert property ((reg_wr_i && reg_addr_i == 9'h10E) |=>
    cascade_ratio_o[7:0] == $past(reg_wdata_i))
    else $error("Cascade ratio low byte misplaced.");
  a_filt_write_bit: assert property ((reg_wr_i && reg_addr_i == 9'h104) |=>
    loop_filter_bypass_o == $past(reg_wdata_i[0]))
    else $error("Filter bypass bit not written.");
  a_ref_write_field: assert property ((reg_wr_i && reg_addr_i == 9'h105) |=>
    ref_div_ratio_o == $past(reg_wdata_i[5:0]))
    else $error("Reference ratio field not written.");
  a_int_write_field: assert property ((reg_wr_i && reg_addr_i == 9'h107) |=>
    fb_int_ratio_o == $past(reg_wdata_i))
    else $error("Feedback integer field not written.");
  a_words_reset_zero: assert property ($fell(sys_rst_i) |->
    (sdm_frac_o == 24'h000000) && (sdm_mod_o == 24'h000000))
    else $error("Fraction or modulus word not zero after reset.");
  a_casc_reset_zero: assert property ($fell(sys_rst_i) |-> cascade_ratio_o == 12'h000)
    else $error("Cascade ratio not zero after reset.");
  a_path_after_reset: assert property ($fell(sys_rst_i) |-> (fb_path_o == 3'h0) ##1 (fb_path_o == 3'h1))
    else $error("Single feedback path not selected after reset.");
  a_fd_reset_low: assert property ($fell(sys_rst_i) |-> !fd_div_o)
    else $error("Fixed-delay output not low after reset.");
  a_sdm_follows_ctrl: assert property ((reg_wr_i && hit_ctrl) |-> ##2
    (sdm_enable_o == !$past(reg_wdata_i[0], 2)))
    else $error("Modulator enable does not follow power-down bit.");
  a_ctrl_readback: assert property (s_ctrl_write_read |=>
    reg_rdata_o == {5'h00, $past(reg_wdata_i[2:0], 2)})
    else $error("Loop control readback mismatch.");
  a_casc_rsvd_zero: assert property (s_casc_write_read |=>
    reg_rdata_o == {4'h0, $past(reg_wdata_i[3:0], 2)})
    else $error("Cascade high reserved bits not zero.");
  a_unmapped_read_zero: assert property ((reg_rd_i && reg_addr_i == 9'h106) |=>
    reg_rdata_o == 8'h00)
    else $error("Unmapped address did not read zero.");
endmodule : sld_regbank
`default_nettype wire

// >>> verif/sld_tb.sv
// Self-checking testbench for the synthesizer loop divider register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module testbench;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [8:0] reg_addr_i = 9'h000;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic fd_half_tick_i = 1'b0;
  logic fd_restart_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic loop_filter_bypass_o;
  logic [5:0] ref_div_ratio_o;
  logic [7:0] fb_int_ratio_o;
  logic [23:0] sdm_frac_o;
  logic [23:0] sdm_mod_o;
  logic sdm_enable_o;
  logic [11:0] cascade_ratio_o;
  logic [2:0] fb_path_o;
  logic fd_div_o;
  logic config_error_o;
  int m [int];
  int mismatches = 0;
  int checks_done = 0;
  int seed = 32'hC5E2E5F6;
  int cnt;
  int tbl [24] = '{20'h1070B, 20'h1070C, 20'h10100, 20'h1070E, 20'h1070F, 20'h107FC, 20'h107FD, 20'h10101,
    20'h107FF, 20'h10E03, 20'h10E04, 20'h10FFF, 20'h10E00, 20'h10B05, 20'h10805, 20'h10B06, 20'h10102,
    20'h10106, 20'h10107, 20'h10500, 20'h1053F, 20'h104FF, 20'h110FF, 20'h111C0};

  sld_regbank i_dut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .fd_half_tick_i(fd_half_tick_i),
    .fd_restart_i(fd_restart_i), .loop_filter_bypass_o(loop_filter_bypass_o),
    .ref_div_ratio_o(ref_div_ratio_o), .fb_int_ratio_o(fb_int_ratio_o), .sdm_frac_o(sdm_frac_o),
    .sdm_mod_o(sdm_mod_o), .sdm_enable_o(sdm_enable_o), .cascade_ratio_o(cascade_ratio_o),
    .fb_path_o(fb_path_o), .fd_div_o(fd_div_o), .config_error_o(config_error_o));

  initial
  begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  // --------------------------------------------------------------
  // Reference model
  // --------------------------------------------------------------
  function automatic int msk(int a);
    case (a)
      9'h101: return 8'h07;
      9'h104: return 8'h01;
      9'h105, 9'h110, 9'h111: return 8'h3F;
      9'h10F: return 8'h0F;
      default: return (a >= 9'h107 && a <= 9'h10E) ? 8'hFF : 0;
    endcase
  endfunction : msk

  function automatic int w24(int a);
    return (m[a + 2] << 16) | (m[a + 1] << 8) | m[a];
  endfunction : w24

  function automatic int st();
    int iv;
    int cs;
    iv = m[9'h107];
    cs = (m[9'h10F] << 8) | m[9'h10E];
    return (iv < 12) | (((iv >= 12 && iv <= 14 || iv >= 253) && !(m[9'h101] & 1)) << 1) | ((cs < 4) << 2)
      | ((w24(9'h10B) <= w24(9'h108)) << 3) | ((((m[9'h101] >> 1) & 3) == 3) << 4) | ((m[9'h105] == 0) << 5);
  endfunction : st

  // --------------------------------------------------------------
  // Port tasks
  // --------------------------------------------------------------
  task automatic do_reset();
    @(posedge core_clk_i);
    sys_rst_i <= 1'b1;
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    for (int a = 9'h100; a <= 9'h113; a++) m[a] = 0;
    m[9'h101] = 1;
    m[9'h105] = 1;
    m[9'h107] = 8'h64;
  endtask : do_reset

  // The strobe is left high so that the next task may follow with no gap.
  task automatic wr(input int a, input int d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_rd_i <= 1'b0;
    reg_addr_i <= a[8:0];
    reg_wdata_i <= d[7:0];
    m[a] = (msk(a) != 0) ? (d & msk(a)) : m[a];
    @(negedge core_clk_i);
  endtask : wr

  task automatic rd(input int a);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_wr_i <= 1'b0;
    reg_addr_i <= a[8:0];
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge core_clk_i);
    `CHK(reg_rdata_o, 8'((a == 9'h112) ? st() : m[a]))
  endtask : rd

  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
    end
    @(negedge core_clk_i);
  endtask : idle

  task automatic chk_ports();
    int mode;
    mode = (m[9'h101] >> 1) & 3;
    `CHK(loop_filter_bypass_o, 1'(m[9'h104]))
    `CHK(ref_div_ratio_o, 6'(m[9'h105]))
    `CHK(fb_int_ratio_o, 8'(m[9'h107]))
    `CHK(sdm_frac_o, 24'(w24(9'h108)))
    `CHK(sdm_mod_o, 24'(w24(9'h10B)))
    `CHK(cascade_ratio_o, 12'((m[9'h10F] << 8) | m[9'h10E]))
    `CHK(sdm_enable_o, 1'(~m[9'h101] & 1))
    `CHK(fb_path_o, 3'((mode == 3) ? 0 : (1 << mode)))
    `CHK(config_error_o, 1'(st() != 0))
    if (mode != 2)
      `CHK(fd_div_o, 1'b0)
  endtask : chk_ports

  // Ticks are random so that the divider sees both dense and sparse input edges.
  task automatic fd_run(input int r, input int p);
    int t;
    int tp;
    wr(9'h110, r);
    wr(9'h111, p);
    wr(9'h101, 8'h04);
    idle(3);
    chk_ports();
    @(posedge core_clk_i);
    fd_restart_i <= 1'b1;
    @(posedge core_clk_i);
    fd_restart_i <= 1'b0;
    cnt = p;
    tp = 0;
    @(negedge core_clk_i);
    `CHK(fd_div_o, 1'(cnt < r + 1))
    repeat (60)
    begin
      @(posedge core_clk_i);
      cnt = !tp ? cnt : ((cnt >= 2 * r + 1) ? 0 : cnt + 1);
      t = $random(seed) & 1;
      fd_half_tick_i <= t[0];
      @(negedge core_clk_i);
      `CHK(fd_div_o, 1'(cnt < r + 1))
      tp = t;
    end
    @(posedge core_clk_i);
    fd_half_tick_i <= 1'b0;
  endtask : fd_run

  task automatic summarize();
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    do_reset();
    idle(2);
    chk_ports();
    for (int a = 9'h100; a <= 9'h113; a++) rd(a);
    foreach (tbl[i])
    begin
      wr(tbl[i] >> 8, tbl[i] & 8'hFF);
      idle(2);
      chk_ports();
      rd(9'h112);
    end
    repeat (6)
    begin
      for (int a = 9'h100; a <= 9'h113; a++)
      begin
        wr(a, $random(seed));
        rd(a);
      end
      idle(2);
      chk_ports();
    end
    fd_run(0, 0);
    fd_run(2, 1);
    fd_run(3, 7);
    fd_run(5, 40);
    fd_run(1, 63);
    wr(9'h101, 8'h00);
    idle(3);
    chk_ports();
    do_reset();
    idle(2);
    chk_ports();
    for (int a = 9'h100; a <= 9'h113; a++) rd(a);
    summarize();
  end

  initial
  begin
    #200000;
    mismatches++;
    summarize();
  end
endmodule : testbench
`default_nettype wire
